// *** rtl/bss_defines.svh ***
// Timing constants for the burner safety sequencer.
`ifndef BSS_DEFINES_SVH
`define BSS_DEFINES_SVH

// =====================================================================
// Clock and common tick
// =====================================================================
`define BSS_CLK_KHZ 250000
`define BSS_TICK_MS 100
`define BSS_TICK_CYCLES (`BSS_CLK_KHZ * `BSS_TICK_MS)

// =====================================================================
// Sequence times in milliseconds and their counts in ticks
// =====================================================================
`define BSS_T_INIT_MS 3500
`define BSS_T_PREPURGE_MS 15000
`define BSS_T_LIGHT_MS 25000
`define BSS_T_PREIGN_MS 2000
`define BSS_T_SAFETY_MS 5000
`define BSS_T_POSTIGN_MS 3000
`define BSS_T_UNLOCK_MS 400
`define BSS_T_SDT_MIN_MS 5000
`define BSS_T_SDT_MAX_MS 10000
`define BSS_T_BTN_FAULT_MS 60000
`define BSS_T_CREDIT_MS 510000
`define BSS_T_INTERMIT_1H_MS 3600000
`define BSS_T_INTERMIT_24H_MS 86400000

`define BSS_N_INIT (`BSS_T_INIT_MS / `BSS_TICK_MS)
`define BSS_N_PREPURGE (`BSS_T_PREPURGE_MS / `BSS_TICK_MS)
`define BSS_N_LIGHT (`BSS_T_LIGHT_MS / `BSS_TICK_MS)
`define BSS_N_PREIGN (`BSS_T_PREIGN_MS / `BSS_TICK_MS)
`define BSS_N_SAFETY (`BSS_T_SAFETY_MS / `BSS_TICK_MS)
`define BSS_N_POSTIGN (`BSS_T_POSTIGN_MS / `BSS_TICK_MS)
`define BSS_N_UNLOCK (`BSS_T_UNLOCK_MS / `BSS_TICK_MS)
`define BSS_N_SDT_MIN (`BSS_T_SDT_MIN_MS / `BSS_TICK_MS)
`define BSS_N_SDT_MAX (`BSS_T_SDT_MAX_MS / `BSS_TICK_MS)
`define BSS_N_BTN_FAULT (`BSS_T_BTN_FAULT_MS / `BSS_TICK_MS)
`define BSS_N_CREDIT (`BSS_T_CREDIT_MS / `BSS_TICK_MS)
`define BSS_N_INTERMIT_1H (`BSS_T_INTERMIT_1H_MS / `BSS_TICK_MS)
`define BSS_N_INTERMIT_24H (`BSS_T_INTERMIT_24H_MS / `BSS_TICK_MS)

// =====================================================================
// Counter allowances and indication
// =====================================================================
`define BSS_RECYCLES_MAX 2'd3
`define BSS_RESETS_MAX 3'd5
`define BSS_LIGHT_TOLERATED 2'd2
`define BSS_QUALITY_STEADY 4'd6
`define BSS_BLINK_FRAME 7'd79

`endif

// *** rtl/bss_pkg.sv ***
// Types shared by the burner safety sequencer.
package bss_pkg;

    // =================================================================
    // Sequence states and lockout causes
    // =================================================================
    typedef enum logic [2:0] {
        ST_STANDBY,
        ST_INIT,
        ST_PREPURGE,
        ST_PREIGN,
        ST_SAFETY,
        ST_RUN,
        ST_LOCKOUT
    } bss_state_e;

    typedef enum logic [1:0] {
        CAUSE_NOFLAME,
        CAUSE_LIGHT,
        CAUSE_RECYCLE,
        CAUSE_FAN
    } bss_cause_e;

    // =================================================================
    // Complete register state of the sequencer
    // =================================================================
    typedef struct packed {
        bss_state_e st;
        bss_cause_e cause;
        logic [24:0] tick_cnt;
        logic tick;
        logic [9:0] timer;
        logic [7:0] light_timer;
        logic [1:0] light_cnt;
        logic light_prev;
        logic [9:0] btn_time;
        logic btn_fault;
        logic heat;
        logic limit_prev;
        logic recycling;
        logic [1:0] recycles;
        logic [2:0] resets;
        logic [19:0] run_time;
        logic [12:0] credit;
        logic [4:0] spark_time;
        logic [6:0] blink;
        logic fan;
        logic spark;
        logic valve;
        logic lamp;
        logic led_red;
        logic led_green;
        logic led_orange;
    } bss_state_s;

endpackage : bss_pkg

// *** rtl/bss_sequencer.sv ***
// Sequencer for a single-stage oil burner control box.
// =====================================================================
// How it works
// - Button held 5 to 10 s then released: shut valve, restart start-up.
// - Shutdown test refills recycle and reset allowances.
// - In run, green steady above six steps, else one blink per step.
// - After 1 h (or 24 h) continuous run, switch off and restart.
// - Flame failure in run recycles up to three times; fourth locks out.
// - New demand during recycle: limit thermostat switch restores three.
// - Every 510 s of uninterrupted run adds one recycle, capped at three.
// - Power-up with new heat request starts with three recycles.
// - Light in init check keeps fan off until gone or lockout.
// - Light in pre-purge: fan stays on, purge restarts, 25 s countdown.
// - Pre-purge light appearances are cumulative; the third locks out.
// - Light during a recycle start-up starts the same 25 s countdown.
// - Spark 2 s before valve, through safety time, 3 s after it.
// - External lamp lit whenever the burner is in lockout.
// - Heat request read only with button released; held button blocks start.
// - Request held at most 60 s while pressed, then cleared and flagged.
// - Unlock needs at least 0.4 s press, acts on release, supply present.
// - At most five consecutive resets until power is cycled.
// - Frequency fault: no start before demand, hold purge, keep running.
// - Voltage anomaly blocks start, run continues, restart when cleared.
// - Button stuck over 60 s: LED flag, run stops, lockout reset blocked.
// - Fan motor fault causes lockout with its own LED pattern.
// - Pre-purge runs the fan 15 s before ignition.
// - No flame at end of safety time: lockout with steady red.
`timescale 1ns/1ps
`default_nettype none
`include "bss_defines.svh"

module bss_sequencer
    import bss_pkg::*;
#(
    parameter int TICK_CYCLES = `BSS_TICK_CYCLES
)
(
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic heat_request_thermostat_i,
    input wire logic limit_thermostat_i,
    input wire logic button_i,
    input wire logic flame_i,
    input wire logic [3:0] flame_strength_i,
    input wire logic freq_ok_i,
    input wire logic volt_ok_i,
    input wire logic fan_ok_i,
    input wire logic intermit_24h_i,
    output logic fan_o,
    output logic ignition_o,
    output logic oil_valve_o,
    output logic lockout_lamp_o,
    output logic led_red_o,
    output logic led_green_o,
    output logic led_orange_o
);

    // =================================================================
    // Blink pattern helpers
    // =================================================================
    function automatic logic slow_on(input logic [6:0] b);
        slow_on = (b % 7'd10) < 7'd5;
    endfunction : slow_on

    function automatic logic fast_on(input logic [6:0] b);
        fast_on = (b % 7'd4) < 7'd2;
    endfunction : fast_on

    // One blink per signal step, steady above the top step.
    function automatic logic quality_on(input logic [3:0] n,
                                        input logic [6:0] b);
        logic [6:0] lim;
        lim = 7'(n) * 7'd10;
        if (n > `BSS_QUALITY_STEADY)
            quality_on = 1'b1;
        else
            quality_on = (b < lim) && slow_on(b);
    endfunction : quality_on

    bss_state_s q;
    bss_state_s d;
    logic released;
    logic sdt;
    logic in_fan;
    logic ready;

    // =================================================================
    // Next state
    // =================================================================
    always_comb
    begin
        d = q;
        // A common 0.1 s tick paces every timer.
        d.tick = 1'b0;
        d.tick_cnt = q.tick_cnt + 25'd1;
        if (q.tick_cnt >= 25'(TICK_CYCLES - 1))
        begin
            d.tick_cnt = '0;
            d.tick = 1'b1;
        end
        if (q.tick)
            d.blink = (q.blink >= `BSS_BLINK_FRAME) ? 7'd0 : q.blink + 7'd1;

        released = !button_i && (q.btn_time != 10'd0);
        sdt = released && q.btn_time >= 10'(`BSS_N_SDT_MIN)
            && q.btn_time < 10'(`BSS_N_SDT_MAX);
        if (!button_i)
            d.btn_time = '0;
        else if (q.tick && q.btn_time != 10'h3ff)
            d.btn_time = q.btn_time + 10'd1;
        d.btn_fault = button_i && q.btn_time >= 10'(`BSS_N_BTN_FAULT);

        // The request is sampled only with the button up; while it is
        // pressed the last value is held, but never past the fault time.
        if (!button_i)
            d.heat = heat_request_thermostat_i;
        else if (q.btn_time >= 10'(`BSS_N_BTN_FAULT))
            d.heat = 1'b0;
        d.limit_prev = limit_thermostat_i;

        // New demand while recycling: limit switch refills attempts.
        if (q.recycling && q.heat && limit_thermostat_i != q.limit_prev)
            d.recycles = `BSS_RECYCLES_MAX;

        in_fan = q.st == ST_PREPURGE || q.st == ST_PREIGN
              || q.st == ST_SAFETY || q.st == ST_RUN;
        ready = freq_ok_i && volt_ok_i;

        if (in_fan && !fan_ok_i)
        begin
            d.st = ST_LOCKOUT;
            d.cause = CAUSE_FAN;
        end
        else if (q.st != ST_LOCKOUT && q.st != ST_STANDBY && !q.heat)
            d.st = ST_STANDBY;
        else if (sdt && (q.st == ST_RUN || q.st == ST_STANDBY))
        begin
            // Shutdown test: drop valve and flame, start over.
            d.st = ST_STANDBY;
            d.recycles = `BSS_RECYCLES_MAX;
            d.resets = `BSS_RESETS_MAX;
            d.recycling = 1'b0;
        end
        else
        begin
            case (q.st)
                ST_STANDBY:
                begin
                    d.timer = '0;
                    d.light_timer = '0;
                    d.light_cnt = '0;
                    // A held or stuck button keeps the burner off.
                    if (q.heat && !button_i)
                        d.st = ST_INIT;
                end
                ST_INIT:
                begin
                    if (flame_i)
                    begin
                        // Fan stays off while light is seen.
                        if (q.tick)
                            d.light_timer = q.light_timer + 8'd1;
                        if (q.light_timer >= 8'(`BSS_N_LIGHT))
                        begin
                            d.st = ST_LOCKOUT;
                            d.cause = CAUSE_LIGHT;
                        end
                    end
                    else if (ready && q.tick)
                    begin
                        // Supply faults freeze the check.
                        d.light_timer = '0;
                        d.timer = q.timer + 10'd1;
                        if (q.timer >= 10'(`BSS_N_INIT - 1))
                        begin
                            d.st = ST_PREPURGE;
                            d.timer = '0;
                            d.light_prev = 1'b0;
                        end
                    end
                    else if (!ready)
                        d.light_timer = '0;
                end
                ST_PREPURGE:
                begin
                    d.light_prev = flame_i;
                    if (flame_i)
                    begin
                        d.timer = '0;
                        if (!q.light_prev)
                        begin
                            d.light_timer = '0;
                            d.light_cnt = q.light_cnt + 2'd1;
                            if (q.light_cnt >= `BSS_LIGHT_TOLERATED)
                            begin
                                d.st = ST_LOCKOUT;
                                d.cause = CAUSE_LIGHT;
                            end
                        end
                        else if (q.light_timer >= 8'(`BSS_N_LIGHT))
                        begin
                            d.st = ST_LOCKOUT;
                            d.cause = CAUSE_LIGHT;
                        end
                        else if (q.tick)
                            d.light_timer = q.light_timer + 8'd1;
                    end
                    else if (freq_ok_i && q.tick)
                    begin
                        // Purge holds under a frequency fault.
                        d.timer = q.timer + 10'd1;
                        if (q.timer >= 10'(`BSS_N_PREPURGE - 1))
                        begin
                            d.st = ST_PREIGN;
                            d.timer = '0;
                        end
                    end
                end
                ST_PREIGN:
                begin
                    if (q.tick)
                        d.timer = q.timer + 10'd1;
                    if (q.tick && q.timer >= 10'(`BSS_N_PREIGN - 1))
                    begin
                        d.st = ST_SAFETY;
                        d.timer = '0;
                    end
                end
                ST_SAFETY:
                begin
                    if (q.tick)
                        d.timer = q.timer + 10'd1;
                    if (q.tick && q.timer >= 10'(`BSS_N_SAFETY - 1))
                    begin
                        d.timer = '0;
                        d.spark_time = '0;
                        d.run_time = '0;
                        d.credit = '0;
                        if (flame_i)
                            d.st = ST_RUN;
                        else
                        begin
                            d.st = ST_LOCKOUT;
                            d.cause = CAUSE_NOFLAME;
                        end
                    end
                end
                ST_RUN:
                begin
                    if (q.tick && q.spark_time < 5'(`BSS_N_POSTIGN))
                        d.spark_time = q.spark_time + 5'd1;
                    if (q.tick)
                    begin
                        d.run_time = q.run_time + 20'd1;
                        d.credit = q.credit + 13'd1;
                    end
                    if (q.tick && q.credit >= 13'(`BSS_N_CREDIT - 1))
                    begin
                        d.credit = '0;
                        if (q.recycles < `BSS_RECYCLES_MAX)
                            d.recycles = q.recycles + 2'd1;
                    end
                    if (!flame_i)
                    begin
                        d.timer = '0;
                        d.light_timer = '0;
                        d.light_cnt = '0;
                        if (q.recycles == 2'd0)
                        begin
                            d.st = ST_LOCKOUT;
                            d.cause = CAUSE_RECYCLE;
                        end
                        else
                        begin
                            d.st = ST_INIT;
                            d.recycles = q.recycles - 2'd1;
                            d.recycling = 1'b1;
                        end
                    end
                    else if (q.btn_fault)
                        d.st = ST_STANDBY;
                    else if (q.run_time >= (intermit_24h_i
                             ? 20'(`BSS_N_INTERMIT_24H)
                             : 20'(`BSS_N_INTERMIT_1H)))
                    begin
                        d.st = ST_STANDBY;
                        d.recycling = 1'b0;
                    end
                    else if (q.credit == 13'd0 && q.run_time != 20'd0)
                        d.recycling = 1'b0;
                end
                ST_LOCKOUT:
                begin
                    // Unlock on release only; stuck button and an
                    // exhausted reset allowance both refuse it.
                    if (released && volt_ok_i
                        && q.btn_time >= 10'(`BSS_N_UNLOCK)
                        && q.btn_time < 10'(`BSS_N_BTN_FAULT)
                        && q.resets != 3'd0)
                    begin
                        d.st = ST_STANDBY;
                        d.resets = q.resets - 3'd1;
                        d.recycles = `BSS_RECYCLES_MAX;
                        d.recycling = 1'b0;
                    end
                end
                default:
                    d.st = ST_LOCKOUT;
            endcase
        end

        // Actuators follow the next state so they leave flip-flops.
        d.fan = d.st == ST_PREPURGE || d.st == ST_PREIGN
             || d.st == ST_SAFETY || d.st == ST_RUN;
        d.spark = d.st == ST_PREIGN || d.st == ST_SAFETY
               || (d.st == ST_RUN
                   && d.spark_time < 5'(`BSS_N_POSTIGN));
        d.valve = d.st == ST_SAFETY || d.st == ST_RUN;
        d.lamp = d.st == ST_LOCKOUT;

        d.led_red = 1'b0;
        d.led_green = 1'b0;
        d.led_orange = 1'b0;
        if (d.st == ST_LOCKOUT)
        begin
            case (d.cause)
                CAUSE_NOFLAME: d.led_red = 1'b1;
                CAUSE_LIGHT: d.led_red = slow_on(d.blink);
                CAUSE_RECYCLE: d.led_red = fast_on(d.blink);
                CAUSE_FAN:
                begin
                    d.led_red = slow_on(d.blink);
                    d.led_orange = !slow_on(d.blink);
                end
                default: d.led_red = 1'b1;
            endcase
        end
        else if (d.btn_fault)
        begin
            d.led_green = fast_on(d.blink);
            d.led_red = !fast_on(d.blink);
        end
        else if (!freq_ok_i && d.st != ST_RUN)
            d.led_orange = 1'b1;
        else if (!volt_ok_i && d.st != ST_RUN)
        begin
            d.led_orange = fast_on(d.blink);
            d.led_green = !fast_on(d.blink);
        end
        else if (d.st == ST_PREPURGE)
            d.led_orange = slow_on(d.blink);
        else if (d.st == ST_PREIGN || d.st == ST_SAFETY)
            d.led_green = slow_on(d.blink);
        else if (d.st == ST_RUN)
            d.led_green = quality_on(flame_strength_i, d.blink);
    end

    // =================================================================
    // State register
    // =================================================================
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            q <= '0;
            q.st <= ST_STANDBY;
            // Power-up grants full allowances.
            q.recycles <= `BSS_RECYCLES_MAX;
            q.resets <= `BSS_RESETS_MAX;
        end
        else
            q <= d;
    end

    assign fan_o = q.fan;
    assign ignition_o = q.spark;
    assign oil_valve_o = q.valve;
    assign lockout_lamp_o = q.lamp;
    assign led_red_o = q.led_red;
    assign led_green_o = q.led_green;
    assign led_orange_o = q.led_orange;

    // =================================================================
    // Assertions
    // =================================================================
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    a_lamp_lockout: assert property (
        lockout_lamp_o == (q.st == ST_LOCKOUT) && !(lockout_lamp_o && fan_o))
        else $error("lamp does not match lockout");
    a_valve_spark: assert property (
        $rose(oil_valve_o) |-> ignition_o && $past(ignition_o))
        else $error("valve opened without spark");
    a_init_fan_off: assert property (
        (q.st == ST_INIT && flame_i) |=> !fan_o)
        else $error("fan runs with light in init");
    a_purge_fan_on: assert property (
        (q.st == ST_PREPURGE && flame_i && fan_ok_i && q.heat)
        |=> fan_o || lockout_lamp_o)
        else $error("fan stopped during purge light");
    a_recycle_cap: assert property (
        q.recycles <= `BSS_RECYCLES_MAX && q.resets <= `BSS_RESETS_MAX)
        else $error("allowance above its maximum");
    a_reset_count: assert property (
        ($past(q.st) == ST_LOCKOUT && q.st == ST_STANDBY)
        |-> q.resets == $past(q.resets) - 3'd1 && $past(released))
        else $error("unlock without release or count");
    a_shutdown_refill: assert property (
        (sdt && q.st == ST_RUN && fan_ok_i && q.heat)
        |=> q.recycles == `BSS_RECYCLES_MAX && q.resets == `BSS_RESETS_MAX
            && q.st == ST_STANDBY ##1 !oil_valve_o)
        else $error("shutdown test did not refill");
    a_held_no_start: assert property (
        (q.st == ST_STANDBY && button_i) |=> q.st != ST_INIT)
        else $error("start with button held");

endmodule : bss_sequencer
`default_nettype wire

// *** verification/bss_burner_model.sv ***
// Burner-side model: flame sensor, stray light and fan motor.
`timescale 1ns/1ps
`default_nettype none
module bss_burner_model (
    input wire logic ref_clk_i,
    input wire logic oil_valve_i,
    input wire logic burn_i,
    input wire logic stray_i,
    input wire logic fan_bad_i,
    output logic flame_o,
    output logic fan_ok_o
);
    // Updated off the sampling edge, so the design never races the model.
    always @(negedge ref_clk_i) flame_o <= (oil_valve_i & burn_i) | stray_i;
    always @(negedge ref_clk_i) fan_ok_o <= !fan_bad_i;
endmodule : bss_burner_model
`default_nettype wire

// *** verification/tb_bss_sequencer.sv ***
// Self-checking bench for the burner safety sequencer.
`timescale 1ns/1ps
`default_nettype none
module tb_bss_sequencer;
    logic ref_clk_i = 1'b0, rst_n_i = 1'b0, heat = 1'b0, button = 1'b0;
    logic burn = 1'b0, stray = 1'b0, fan_bad = 1'b0;
    logic flame, fan_ok, fan_o, ignition_o, oil_valve_o, lamp, red, green;
    logic orange;
    logic freq = 1'b1;
    logic [3:0] strength = 4'hf;
    int errors = 0, samples_checked = 0, n;
    initial forever #2 ref_clk_i = ~ref_clk_i;
    bss_sequencer #(.TICK_CYCLES(4)) bss_sequencer_i (
        .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .button_i(button),
        .heat_request_thermostat_i(heat), .limit_thermostat_i(1'b0),
        .flame_i(flame), .flame_strength_i(strength), .freq_ok_i(freq),
        .volt_ok_i(1'b1), .fan_ok_i(fan_ok), .intermit_24h_i(1'b0),
        .fan_o(fan_o), .ignition_o(ignition_o), .oil_valve_o(oil_valve_o),
        .lockout_lamp_o(lamp), .led_red_o(red), .led_green_o(green),
        .led_orange_o(orange)
    );
    bss_burner_model bss_burner_model_i (.ref_clk_i(ref_clk_i),
        .oil_valve_i(oil_valve_o), .burn_i(burn), .stray_i(stray),
        .fan_bad_i(fan_bad), .flame_o(flame), .fan_ok_o(fan_ok));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        errors += (seen !== exp);
        if (seen !== exp)
            $display("[ERR] %0t got %0h want %0h", $time, seen, exp);
    endtask : check
    task automatic conclude();
        if (errors == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : conclude
    task automatic wait_for(input logic [3:0] m, input logic [3:0] v);
        for (n = 0; n < 5000
             && ({lamp, oil_valve_o, ignition_o, fan_o} & m) !== v; n++)
            @(negedge ref_clk_i);
        check(n < 5000, 1'b1);
        if (n >= 5000)
            conclude();
    endtask : wait_for
    task automatic press(input int c);
        button = 1'b1;
        repeat (c) @(negedge ref_clk_i);
        button = 1'b0;
        repeat (8) @(negedge ref_clk_i);
    endtask : press
    task automatic start_run();
        heat = 1'b1;
        burn = 1'b1;
        wait_for(4'h1, 4'h1);
        freq = 1'b0;
        repeat (800) @(negedge ref_clk_i);
        check({orange, ignition_o, fan_o}, 3'b101);
        freq = 1'b1;
        wait_for(4'h2, 4'h2);
        check(n, 600);
        wait_for(4'h4, 4'h4);
        check(n, 80);
        wait_for(4'h2, 4'h0);
        check(n, 320);
        repeat (320) @(negedge ref_clk_i) n += green;
        check(n, 640);
        strength = 4'h2;
        n = 0;
        repeat (320) @(negedge ref_clk_i) n += green;
        check(n, 40);
    endtask : start_run
    task automatic shutdown_test();
        burn = 1'b0;
        repeat (8) @(negedge ref_clk_i);
        burn = 1'b1;
        wait_for(4'h4, 4'h4);
        wait_for(4'h2, 4'h0);
        press(240);
        check({oil_valve_o, fan_o}, 2'b00);
    endtask : shutdown_test
    task automatic recycles();
        for (int i = 0; i < 4; i++)
        begin
            burn = 1'b1;
            wait_for(4'h4, 4'h4);
            wait_for(4'h2, 4'h0);
            burn = 1'b0;
            repeat (8) @(negedge ref_clk_i);
            check({fan_o, lamp}, {1'b0, i == 3});
        end
        press(40);
    endtask : recycles
    task automatic no_flame();
        burn = 1'b0;
        wait_for(4'h4, 4'h4);
        wait_for(4'h8, 4'h8);
        check({red, oil_valve_o, n[9:0]}, {2'b10, 10'd200});
        press(2);
        check(lamp, 1'b1);
        press(40);
        check(lamp, 1'b0);
    endtask : no_flame
    task automatic stray_light();
        wait_for(4'h1, 4'h1);
        for (int i = 0; i < 6; i++)
        begin
            stray = ~stray;
            repeat (40) @(negedge ref_clk_i);
            check({fan_o, lamp}, i > 3 ? 2'b01 : 2'b10);
        end
        press(40);
    endtask : stray_light
    task automatic fan_fault();
        for (int j = 0; j < 3; j++)
        begin
            wait_for(4'h1, 4'h1);
            fan_bad = 1'b1;
            repeat (8) @(negedge ref_clk_i);
            fan_bad = 1'b0;
            check({fan_o, lamp}, 2'b01);
            press(40);
            check(lamp, j == 2);
        end
    endtask : fan_fault
    initial
    begin
        repeat (10) @(negedge ref_clk_i);
        check({lamp, oil_valve_o, ignition_o, fan_o}, 4'h0);
        rst_n_i = 1'b1;
        @(negedge ref_clk_i);
        start_run();
        shutdown_test();
        recycles();
        no_flame();
        stray_light();
        fan_fault();
        conclude();
    end
endmodule : tb_bss_sequencer
`default_nettype wire
